// ### verilog/odsl_host.sv
/*
 host end of the octal dac serial load link: takes frames from the user,
 makes the link clock by dividing core_clk_i, shifts twelve bits msb
 first, pulses the load strobe after the last frame of a chain, drives
 preset, and collects the readback bits.
 assumes the device end samples on the rising link clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module odsl_host
	import odsl_pkg::*;
#(
	parameter int SCLK_HALF_CYC = ODSL_SCLK_HALF_CYC,
	parameter int SETTLE_CYC = ODSL_SETTLE_CYC,
	parameter int LOAD_CYC = ODSL_LOAD_CYC,
	parameter int GAP_CYC = ODSL_GAP_CYC
)(
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic [ODSL_ADDR_W-1:0] req_addr_i,
	input wire logic [ODSL_CODE_W-1:0] req_code_i,
	input wire logic req_last_i,
	input wire logic preset_i,
	output var logic rd_valid_o,
	output var logic [ODSL_FRAME_W-1:0] rd_frame_o,
	odsl_link_if.host link
);

	////////////////////////////////////////////////////////////////////
	// state and next values

	odsl_hstate_t state, next_state;
	logic [ODSL_TMR_W-1:0] tmr, next_tmr;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [ODSL_FRAME_W-1:0] shreg, next_shreg;
	logic [ODSL_FRAME_W-1:0] rd_sh, next_rd_sh;
	logic last, next_last;
	logic next_rd_valid;
	logic so_meta, so_sync;
	logic sclk, sdat, load, force_n;

	wire logic tmr_zero;
	wire logic take;
	assign tmr_zero = (tmr == '0);
	assign take = req_valid_i & req_ready_o;
	assign req_ready_o = (state == ODSL_H_IDLE) & ~preset_i;

	////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		next_state = state;
		next_tmr = tmr_zero ? tmr : tmr - 8'h01;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_rd_sh = rd_sh;
		next_last = last;
		next_rd_valid = 1'b0;
		case (state)
			ODSL_H_IDLE: begin
				if (preset_i) begin
					next_state = ODSL_H_PRESET;
				end else if (take) begin
					// address first, then code, both msb first
					next_shreg = {req_addr_i, req_code_i};
					next_last = req_last_i;
					next_bit_cnt = 4'h0;
					next_tmr = 8'(SCLK_HALF_CYC - 1);
					next_state = ODSL_H_LOW;
				end
			end
			ODSL_H_PRESET: begin
				// leaving preset only to idle keeps the strobe low
				if (!preset_i) begin
					next_state = ODSL_H_IDLE;
				end
			end
			ODSL_H_LOW: begin
				if (tmr_zero) begin
					next_rd_sh = {rd_sh[ODSL_FRAME_W-2:0], so_sync};
					next_tmr = 8'(SCLK_HALF_CYC - 1);
					next_state = ODSL_H_HIGH;
				end
			end
			ODSL_H_HIGH: begin
				if (tmr_zero) begin
					next_shreg = {shreg[ODSL_FRAME_W-2:0], 1'b0};
					next_tmr = 8'(SCLK_HALF_CYC - 1);
					if (bit_cnt == ODSL_LAST_BIT) begin
						next_rd_valid = 1'b1;
						next_tmr = 8'(SETTLE_CYC - 1);
						next_state = last ? ODSL_H_SETTLE : ODSL_H_IDLE;
					end else begin
						next_bit_cnt = bit_cnt + 4'h1;
						next_state = ODSL_H_LOW;
					end
				end
			end
			ODSL_H_SETTLE: begin
				if (tmr_zero) begin
					next_tmr = 8'(LOAD_CYC - 1);
					next_state = ODSL_H_LOAD;
				end
			end
			ODSL_H_LOAD: begin
				// link clock held low for the whole strobe
				if (tmr_zero) begin
					next_tmr = 8'(GAP_CYC - 1);
					next_state = ODSL_H_GAP;
				end
			end
			ODSL_H_GAP: begin
				if (tmr_zero) begin
					next_state = ODSL_H_IDLE;
				end
			end
			default: begin
				next_state = ODSL_H_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= ODSL_H_IDLE;
			tmr <= '0;
			bit_cnt <= 4'h0;
			shreg <= '0;
			rd_sh <= '0;
			last <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_frame_o <= '0;
		end else begin
			state <= next_state;
			tmr <= next_tmr;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			rd_sh <= next_rd_sh;
			last <= next_last;
			rd_valid_o <= next_rd_valid;
			if (next_rd_valid) begin
				rd_frame_o <= rd_sh;
			end
		end
	end

	// link pins come straight from flops, glitch free
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sclk <= 1'b0;
			sdat <= 1'b0;
			load <= 1'b0;
			force_n <= 1'b1;
		end else begin
			sclk <= (next_state == ODSL_H_HIGH);
			sdat <= next_shreg[ODSL_FRAME_W-1];
			load <= (next_state == ODSL_H_LOAD);
			force_n <= (next_state != ODSL_H_PRESET);
		end
	end

	// readback pin is another domain: two flops before use
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			so_meta <= 1'b0;
			so_sync <= 1'b0;
		end else begin
			so_meta <= link.serial_out;
			so_sync <= so_meta;
		end
	end

	assign link.sclk = sclk;
	assign link.serial_in = sdat;
	assign link.load_strobe = load;
	assign link.midscale_force_n = force_n;

endmodule // odsl_host

`default_nettype wire

// ### verilog/odsl_pkg.sv
/*
 constants and types shared by both ends of the octal dac serial load link.
 assumes nothing of its surroundings; compiled before every other file.
*/
`default_nettype none

package odsl_pkg;

	////////////////////////////////////////////////////////////////////
	// frame layout
	localparam int ODSL_ADDR_W = 4;
	localparam int ODSL_CODE_W = 8;
	localparam int ODSL_FRAME_W = ODSL_ADDR_W + ODSL_CODE_W;
	localparam int ODSL_NUM_CH = 8;
	localparam int ODSL_ADDR_MSB = ODSL_FRAME_W - 1;
	localparam int ODSL_ADDR_LSB = ODSL_CODE_W;
	localparam int ODSL_CODE_MSB = ODSL_CODE_W - 1;

	////////////////////////////////////////////////////////////////////
	// address map and values after preset
	localparam logic [ODSL_ADDR_W-1:0] ODSL_ADDR_NOP = 4'h0;
	localparam logic [ODSL_ADDR_W-1:0] ODSL_ADDR_FIRST = 4'h1;
	localparam logic [ODSL_ADDR_W-1:0] ODSL_ADDR_LAST = 4'h8;
	localparam logic [ODSL_CODE_W-1:0] ODSL_MIDSCALE = 8'h80;
	localparam logic [ODSL_FRAME_W-1:0] ODSL_STAGE_RST = 12'h000;

	////////////////////////////////////////////////////////////////////
	// host timing, in core clock cycles
	localparam int ODSL_TMR_W = 8;
	localparam int ODSL_SCLK_HALF_CYC = 4;
	localparam int ODSL_SETTLE_CYC = 2;
	localparam int ODSL_LOAD_CYC = 4;
	localparam int ODSL_GAP_CYC = 2;
	localparam logic [3:0] ODSL_LAST_BIT = 4'hb;

	////////////////////////////////////////////////////////////////////
	// host sequencer states
	typedef enum logic [2:0] {
		ODSL_H_IDLE,
		ODSL_H_PRESET,
		ODSL_H_LOW,
		ODSL_H_HIGH,
		ODSL_H_SETTLE,
		ODSL_H_LOAD,
		ODSL_H_GAP
	} odsl_hstate_t;

endpackage

`default_nettype wire

// ### verilog/odsl_link_if.sv
/*
 the four-wire serial load link plus readback line.
 assumes the host drives clock, data, load and preset, the device drives
 the readback line; all wires are point to point.
*/
`timescale 1ns/10ps
`default_nettype none

interface odsl_link_if;
	logic sclk;
	logic serial_in;
	logic serial_out;
	logic load_strobe;
	logic midscale_force_n;

	modport host (
		output sclk,
		output serial_in,
		input serial_out,
		output load_strobe,
		output midscale_force_n
	);

	modport dev (
		input sclk,
		input serial_in,
		output serial_out,
		input load_strobe,
		input midscale_force_n
	);
endinterface

`default_nettype wire

// ### verilog/odsl_hold_reg.sv
/*
 one channel holding register of the device end.
 assumes its clock is the decoded load strobe for this channel and that
 code_i is stable while that strobe rises.
*/
`timescale 1ns/10ps
`default_nettype none

module odsl_hold_reg
	import odsl_pkg::*;
(
	input wire logic load_clk_i,
	input wire logic force_n_i,
	input wire logic [ODSL_CODE_W-1:0] code_i,
	output var logic [ODSL_CODE_W-1:0] code_o,
	output var logic upd_tgl_o
);

	////////////////////////////////////////////////////////////////////
	// code store: preset wins, else only a routed strobe edge writes
	always_ff @(posedge load_clk_i or negedge force_n_i) begin
		if (!force_n_i) begin
			code_o <= ODSL_MIDSCALE;
			upd_tgl_o <= 1'b0;
		end else begin
			code_o <= code_i;
			upd_tgl_o <= ~upd_tgl_o;
		end
	end

endmodule // odsl_hold_reg

`default_nettype wire

// ### verilog/odsl_device.sv
/*
 device end of the octal dac serial load link: twelve-stage shift
 register on the link clock, address decode, eight holding registers,
 readback output from the last stage.
 assumes the far end sends whole frames, keeps the link clock still while
 the load strobe is high and keeps the strobe low at preset release.
*/
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - shift serial_in on each rising link clock
// - first four frame bits are address, msb first
// - next eight bits are code, msb first
// - load strobe after twelfth bit latches code
// - address decode routes strobe to one register
// - last stage buffered onto serial_out
// - address 0001 selects channel a
// - address 0000 changes no channel
// - addresses 1001 to 1111 change nothing
// - preset low forces all channels to 80
// - host keeps strobe low releasing preset
// - no rising link clock while strobe high
// - load with clock low, strobe high
// - chained devices get no-op addresses except target
// - host is serial master, strobe from gpio

module odsl_device
	import odsl_pkg::*;
(
	odsl_link_if.dev link,
	output var logic [ODSL_NUM_CH*ODSL_CODE_W-1:0] chan_code_o,
	output var logic [ODSL_NUM_CH-1:0] chan_upd_tgl_o,
	output var logic [ODSL_ADDR_W-1:0] frame_addr_o,
	output var logic [ODSL_CODE_W-1:0] frame_code_o,
	output var logic frame_nop_o
);

	////////////////////////////////////////////////////////////////////
	// address decode, one-hot over the channels

	function automatic logic [ODSL_NUM_CH-1:0] odsl_decode(
		input logic [ODSL_ADDR_W-1:0] addr
	);
		logic [ODSL_NUM_CH-1:0] sel;
		logic [ODSL_ADDR_W-1:0] idx;
		sel = '0;
		idx = addr - ODSL_ADDR_FIRST;
		// 0000 and 1001..1111 fall outside and select nothing
		if (addr >= ODSL_ADDR_FIRST && addr <= ODSL_ADDR_LAST) begin
			sel[idx[2:0]] = 1'b1;
		end
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////
	// shift register

	logic [ODSL_FRAME_W-1:0] stage;
	logic [ODSL_FRAME_W-1:0] next_stage;

	// new bit enters stage 0, so the first bit sent ends at the top
	assign next_stage = {stage[ODSL_FRAME_W-2:0], link.serial_in};

	// preset also clears the stages so serial_out is defined
	always_ff @(posedge link.sclk or negedge link.midscale_force_n) begin
		if (!link.midscale_force_n) begin
			stage <= ODSL_STAGE_RST;
		end else begin
			stage <= next_stage;
		end
	end

	////////////////////////////////////////////////////////////////////
	// frame fields

	wire logic [ODSL_ADDR_W-1:0] frame_addr;
	wire logic [ODSL_CODE_W-1:0] frame_code;
	wire logic [ODSL_NUM_CH-1:0] chan_sel;

	assign frame_addr = stage[ODSL_ADDR_MSB:ODSL_ADDR_LSB];
	assign frame_code = stage[ODSL_CODE_MSB:0];
	assign chan_sel = odsl_decode(frame_addr);

	assign frame_addr_o = frame_addr;
	assign frame_code_o = frame_code;
	assign frame_nop_o = ~|odsl_decode(frame_addr);

	////////////////////////////////////////////////////////////////////
	// readback and cascade output

	// top stage flop drives the pin: input delayed by twelve clocks
	assign link.serial_out = stage[ODSL_FRAME_W-1];

	////////////////////////////////////////////////////////////////////
	// holding registers

	wire logic [ODSL_NUM_CH-1:0] chan_load;

	// strobe reaches only the selected register's clock
	assign chan_load = chan_sel & {ODSL_NUM_CH{link.load_strobe}};

	genvar g;
	generate
		for (g = 0; g < ODSL_NUM_CH; g++) begin : g_chan
			odsl_hold_reg u_hold (
				.load_clk_i(chan_load[g]),
				.force_n_i(link.midscale_force_n),
				.code_i(frame_code),
				.code_o(chan_code_o[g*ODSL_CODE_W +: ODSL_CODE_W]),
				.upd_tgl_o(chan_upd_tgl_o[g])
			);
		end
	endgenerate

endmodule // odsl_device

`default_nettype wire

// ### verification/odsl_link_props.sv
/*
 link wire checks for the serial load link.
 assumes core_clk_i clocks the host that makes sclk with four-cycle halves.
*/
`timescale 1ns/10ps
`default_nettype none
module odsl_link_props (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic sclk,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic load_strobe,
	input wire logic midscale_force_n
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	a_load_clk_low: assert property (load_strobe |-> !sclk)
		else $error("link clock high during load");
	a_load_width: assert property (
		$rose(load_strobe) |-> load_strobe[*4] ##1 !load_strobe)
		else $error("load strobe width wrong");
	a_preset_idle: assert property (
		!midscale_force_n |-> !load_strobe && !sclk)
		else $error("activity during preset");
	a_release_low: assert property (
		$rose(midscale_force_n) |-> !load_strobe)
		else $error("strobe high at preset release");
	a_sclk_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("link clock high phase wrong");
	a_sclk_low: assert property ($fell(sclk) |-> !sclk[*4])
		else $error("link clock low phase short");
	a_data_hold: assert property (sclk |-> $stable(serial_in))
		else $error("data moved while clock high");
	a_so_preset: assert property (!midscale_force_n |-> !serial_out)
		else $error("readback not cleared by preset");
	a_so_shift: assert property (
		$changed(serial_out) |-> $rose(sclk) || $fell(midscale_force_n))
		else $error("readback moved without shift");
endmodule // odsl_link_props
`default_nettype wire

// ### verification/octal_dac_serial_load_tb_top.sv
/*
 self-checking bench: host and device joined by the link interface.
 assumes default host timing parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module octal_dac_serial_load_tb_top;
	import odsl_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic req_valid_i = 1'b0;
	logic req_ready_o;
	logic [3:0] req_addr_i = 4'h0;
	logic [7:0] req_code_i = 8'h00;
	logic req_last_i = 1'b0;
	logic preset_i = 1'b0;
	logic rd_valid_o;
	logic [11:0] rd_frame_o;
	logic [63:0] chan_code_o;
	logic [7:0] chan_upd_tgl_o;
	logic [7:0] prev_tgl;
	logic [3:0] frame_addr_o;
	logic [7:0] frame_code_o;
	logic frame_nop_o;
	logic [63:0] exp_ch;
	logic [11:0] prev_frame;
	logic [31:0] seed = 32'hf0a48bbe;
	logic [11:0] rd_q[$];
	logic [10:0] up_q[$];
	int n_mismatch = 0;
	int compares = 0;
	////////////////////////////////////////////////////////////////////
	odsl_link_if link_if();
	odsl_host u_odsl_host (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
		.req_addr_i(req_addr_i), .req_code_i(req_code_i),
		.req_last_i(req_last_i), .preset_i(preset_i),
		.rd_valid_o(rd_valid_o), .rd_frame_o(rd_frame_o),
		.link(link_if.host));
	odsl_device u_odsl_device (.link(link_if.dev),
		.chan_code_o(chan_code_o), .chan_upd_tgl_o(chan_upd_tgl_o),
		.frame_addr_o(frame_addr_o), .frame_code_o(frame_code_o),
		.frame_nop_o(frame_nop_o));
	odsl_link_props u_odsl_link_props (.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i), .sclk(link_if.sclk),
		.serial_in(link_if.serial_in), .serial_out(link_if.serial_out),
		.load_strobe(link_if.load_strobe),
		.midscale_force_n(link_if.midscale_force_n));
	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_hi(input int sel, input logic v);
		int i;
		for (i = 0; i < 300; i++) begin
			@(negedge core_clk_i);
			if ((sel == 0 ? req_ready_o : sel == 1 ? rd_valid_o :
				link_if.midscale_force_n) === v)
				return;
		end
		n_mismatch++;
		$display("[ERR] %0t wait timed out", $time);
		end_of_test();
	endtask
	task automatic send(input logic [3:0] a, input logic [7:0] c,
		input logic l);
		logic ok;
		int idx;
		ok = (a >= ODSL_ADDR_FIRST) && (a <= ODSL_ADDR_LAST);
		idx = int'(a) - 1;
		wait_hi(0, 1'b1);
		req_valid_i = 1'b1;
		req_addr_i = a;
		req_code_i = c;
		req_last_i = l;
		rd_q.push_back(prev_frame);
		prev_frame = {a, c};
		if (l && ok) begin
			up_q.push_back({3'(idx), c});
			exp_ch[8*idx +: 8] = c;
		end
		@(negedge core_clk_i);
		req_valid_i = 1'b0;
		wait_hi(1, 1'b1);
		chk(64'(frame_addr_o), 64'(a));
		chk(64'(frame_code_o), 64'(c));
		chk(64'(frame_nop_o), 64'(!ok));
		if (l)
			wait_hi(0, 1'b1);
		chk(chan_code_o, exp_ch);
	endtask
	task automatic do_preset();
		@(negedge core_clk_i);
		preset_i = 1'b1;
		wait_hi(2, 1'b0);
		repeat (3) @(negedge core_clk_i);
		exp_ch = {8{ODSL_MIDSCALE}};
		chk(chan_code_o, exp_ch);
		chk(64'(chan_upd_tgl_o), 64'h0);
		preset_i = 1'b0;
		wait_hi(2, 1'b1);
		prev_frame = ODSL_STAGE_RST;
	endtask
	////////////////////////////////////////////////////////////////////
	always @(negedge core_clk_i) begin
		if (rd_valid_o === 1'b1) begin
			if (rd_q.size() == 0)
				chk(64'h1, 64'h0);
			else
				chk(64'(rd_frame_o), 64'(rd_q.pop_front()));
		end
		if (link_if.midscale_force_n === 1'b1) begin
			for (int k = 0; k < 8; k++) begin
				if (chan_upd_tgl_o[k] !== prev_tgl[k]) begin
					if (up_q.size() == 0)
						chk(64'h1, 64'h0);
					else
						chk(64'({3'(k), chan_code_o[8*k +: 8]}),
							64'(up_q.pop_front()));
				end
			end
		end
		prev_tgl = chan_upd_tgl_o;
	end
	initial begin
		exp_ch = '0;
		prev_frame = '0;
		repeat (3) @(negedge core_clk_i);
		rst_b_i = 1'b1;
		do_preset();
		for (int a = 0; a < 16; a++) begin
			seed = lfsr(seed);
			send(4'(a), seed[7:0], 1'b1);
		end
		seed = lfsr(seed);
		send(4'h3, seed[7:0], 1'b0);
		send(4'hf, 8'h5a, 1'b1);
		send(4'h2, 8'h11, 1'b0);
		send(4'h8, 8'hff, 1'b1);
		do_preset();
		send(4'h1, 8'h00, 1'b1);
		end_of_test();
	end
endmodule // octal_dac_serial_load_tb_top
`default_nettype wire
